//--- core/drai_top.sv
// receive alarm interrupt registers, flags and request output
`timescale 1ns/10ps
`default_nettype none
module drai_top (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // register port
   input wire logic [drai_pkg::ADDR_W-1:0] i_addr,
   input wire logic [drai_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [drai_pkg::DATA_W-1:0] o_rdata,
   // receive framer overhead
   input wire drai_pkg::drai_frame_t i_frame,
   // interrupt request, active high
   output logic o_irq
);
   import drai_pkg::*;

   drai_event_t evt;
   logic [7:0] enable_q;
   logic [7:0] enable_d;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] flag_set;
   logic [7:0] live_state;
   logic [7:0] rdata_q;
   logic irq_q;
   logic flags_read;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // =========================================================================
   // detectors
   drai_frame_detect u_detect (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_frame(i_frame),
      .o_event(evt)
   );

   // =========================================================================
   // enable register; unused enable bits are kept for read-back only
   always_comb begin
      enable_d = enable_q;
      if (i_wr && hit(i_addr, OFS_INT_ENABLE)) begin
         enable_d = i_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enable_q <= RST_INT_ENABLE;
      end else if (i_clk_en) begin
         enable_q <= enable_d;
      end
   end

   // =========================================================================
   // sticky flags, set wins over the clearing read
   always_comb begin
      flag_set = 8'h00;
      flag_set[BIT_FEF_CHG] = evt.fef_change && enable_q[BIT_FEF_CHG]; // RL1 RL13 RL7
      flag_set[BIT_APP_ID_CHG] = evt.app_id_change && enable_q[BIT_APP_ID_CHG]; // RL6 RL16
      flag_set[BIT_PBIT_ERR] = evt.pbit_error && enable_q[BIT_PBIT_ERR]; // RL10 RL11
   end

   assign flags_read = i_rd && hit(i_addr, OFS_INT_FLAGS);

   always_comb begin
      flags_d = flags_q;
      if (flags_read) begin
         flags_d = 8'h00; // RL15
      end
      flags_d = (flags_d | flag_set) & FLAG_MASK;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_q <= RST_INT_FLAGS;
      end else if (i_clk_en) begin
         flags_q <= flags_d;
      end
   end

   // =========================================================================
   // interrupt request; disabling an enable also masks a pending flag
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_q <= 1'b0;
      end else if (i_clk_en) begin
         irq_q <= |(flags_d & enable_d); // RL2 RL15
      end
   end

   // =========================================================================
   // live state and read data
   always_comb begin
      live_state = 8'h00;
      live_state[BIT_LIVE_FEF] = evt.far_end_fail_state; // RL3
      live_state[BIT_LIVE_APP_ID] = evt.app_id_bit_state; // RL3
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= RST_RDATA;
      end else if (i_clk_en) begin
         rdata_q <= RST_RDATA;
         if (i_rd) begin
            unique case (1'b1)
               hit(i_addr, OFS_LIVE_STATE): rdata_q <= live_state;
               hit(i_addr, OFS_INT_ENABLE): rdata_q <= enable_q;
               hit(i_addr, OFS_INT_FLAGS): rdata_q <= flags_q; // RL15
               default: rdata_q <= RST_RDATA;
            endcase
         end
      end
   end

   assign o_rdata = rdata_q;
   assign o_irq = irq_q;

endmodule
`default_nettype wire

//--- core/drai_pkg.sv
// constants, register map and carriers for the ds3 receive alarm interrupt block
// Functional notes
// (RL1) far-end-fail declare or clear, when enabled, sets status flag bit 3.
// (RL2) any enabled receive event drives the interrupt request output high.
// (RL3) read-only live state register at 0x11 shows far-end-fail and app-id bit.
// (RL4) host reads live far-end-fail state after its change interrupt.
// (RL5) enabled app-id change interrupt fires on every app-id bit value change; the first valid frame after reset only seeds the bit.
// (RL6) app-id change interrupt enabled by bit 2 of enable register 0x12.
// (RL7) enable bit 1 enables its interrupt, 0 disables it.
// (RL8) host polls app-id bit until steady, then picks framing format.
// (RL9) enabled parity error interrupt fires on each p-bit parity error.
// (RL10) parity error interrupt enabled by bit 0 of the enable register.
// (RL11) parity error sets status flag bit 0 of status register 0x13.
// (RL12) host reads parity error counter after a parity error interrupt.
// (RL13) far-end-fail change interrupt enabled by bit 3 of the enable register.
// (RL14) far-end-fail declared on frames with both x bits 0, cleared otherwise.
// (RL15) flags hold until status read; read returns and clears; irq follows flags.
// (RL16) app-id change sets status flag bit 2, not bit 3.
package drai_pkg;

   // =========================================================================
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // =========================================================================
   // register offsets
   localparam logic [7:0] OFS_LIVE_STATE = 8'h11;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h12;
   localparam logic [7:0] OFS_INT_FLAGS = 8'h13;

   // =========================================================================
   // field positions
   localparam int BIT_PBIT_ERR = 0;
   localparam int BIT_APP_ID_CHG = 2;
   localparam int BIT_FEF_CHG = 3;
   localparam int BIT_LIVE_APP_ID = 3;
   localparam int BIT_LIVE_FEF = 4;

   // =========================================================================
   // reset values and masks
   localparam logic [7:0] RST_INT_ENABLE = 8'h00;
   localparam logic [7:0] RST_INT_FLAGS = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;
   localparam logic [7:0] FLAG_MASK = 8'h0D;
   localparam logic [1:0] X_BITS_FAIL = 2'h0;

   // =========================================================================
   // carriers
   typedef struct packed {
      logic frame_valid;
      logic [1:0] x_bits;
      logic app_id_bit;
      logic pbit_error;
   } drai_frame_t;

   typedef struct packed {
      logic fef_change;
      logic app_id_change;
      logic pbit_error;
      logic far_end_fail_state;
      logic app_id_bit_state;
   } drai_event_t;

endpackage

//--- core/drai_frame_detect.sv
// frame-level far-end-fail and app-id bit detectors
`timescale 1ns/10ps
`default_nettype none
module drai_frame_detect (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // per-frame overhead from the receive framer
   input wire drai_pkg::drai_frame_t i_frame,
   // events and live state
   output drai_pkg::drai_event_t o_event
);
   import drai_pkg::*;

   logic fef_q;
   logic app_id_q;
   logic seen_q;
   logic fef_new;
   drai_event_t event_q;

   // =========================================================================
   // detection
   assign fef_new = (i_frame.x_bits == X_BITS_FAIL); // RL14

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fef_q <= 1'b0;
         app_id_q <= 1'b0;
         seen_q <= 1'b0;
      end else if (i_clk_en && i_frame.frame_valid) begin
         fef_q <= fef_new; // RL14
         app_id_q <= i_frame.app_id_bit;
         seen_q <= 1'b1;
      end
   end

   // =========================================================================
   // event pulses, one cycle each, plus registered live far-end-fail and app-id bit state
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         event_q <= '0;
      end else if (i_clk_en) begin
         event_q.fef_change <= i_frame.frame_valid && (fef_new != fef_q); // RL1
         // first frame only seeds the bit, so reset is not reported as a change
         event_q.app_id_change <= i_frame.frame_valid && seen_q &&
                                  (i_frame.app_id_bit != app_id_q); // RL5
         event_q.pbit_error <= i_frame.pbit_error; // RL9
         event_q.far_end_fail_state <= i_frame.frame_valid ? fef_new : fef_q;
         event_q.app_id_bit_state <= i_frame.frame_valid ? i_frame.app_id_bit : app_id_q;
      end
   end

   assign o_event = event_q;

endmodule
`default_nettype wire

//--- test/drai_top_sva.sv
// assertion checker for the receive alarm interrupt top
`timescale 1ns/10ps
`default_nettype none
module drai_top_sva (
   // clock, reset, register port
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // framer side and request
   input wire drai_pkg::drai_frame_t i_frame,
   input wire logic o_irq
);
   import drai_pkg::*;
   logic [7:0] en_q;
   logic fef_q;
   // shadows, so no design internals are needed
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_q <= 8'h00;
         fef_q <= 1'b0;
      end else if (i_clk_en) begin
         if (i_wr && i_addr == OFS_INT_ENABLE) en_q <= i_wdata;
         if (i_frame.frame_valid) fef_q <= i_frame.x_bits == X_BITS_FAIL;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   // a frozen cycle says nothing about event timing
   default disable iff (!i_rst_n || !i_clk_en);
   AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata");
   AST_FLAG_RSVD: assert property (i_rd && i_addr == OFS_INT_FLAGS |=>
      (o_rdata & ~FLAG_MASK) == 8'h00) else $error("flag bits");
   AST_EN_RW: assert property (i_rd && i_addr == OFS_INT_ENABLE |=> o_rdata == en_q)
      else $error("enable");
   AST_PBIT: assert property (i_frame.pbit_error && en_q[0] |-> ##2 o_irq)
      else $error("pbit irq");
   AST_FEF: assert property (i_frame.frame_valid && en_q[3] &&
      ((i_frame.x_bits == X_BITS_FAIL) != fef_q) |-> ##2 o_irq) else $error("fef irq");
   AST_HOLD: assert property (o_irq && !i_rd && !i_wr && !$past(i_rd) && !$past(i_wr)
      |=> o_irq) else $error("irq dropped");
   AST_CLEAR: assert property (i_rd && i_addr == OFS_INT_FLAGS &&
      !(i_frame.frame_valid || i_frame.pbit_error) && !$past(i_frame.frame_valid)
      && !$past(i_frame.pbit_error) |=> !o_irq) else $error("irq kept");
   AST_QUIET: assert property (((en_q & FLAG_MASK) == 8'h00) [*2] |-> !o_irq)
      else $error("irq disabled");
   cover property (o_irq);
   cover property (i_rd && i_addr == OFS_INT_FLAGS && o_irq);
   cover property (i_frame.frame_valid && en_q[2]);
endmodule
bind drai_top drai_top_sva u_sva (.i_clock, .i_rst_n, .i_clk_en, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_frame, .o_irq);
`default_nettype wire

//--- test/drai_host.sv
// host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module drai_host (
   // clock and read data
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   // register port
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   import drai_pkg::*;
   initial {o_addr, o_wdata, o_wr, o_rd} = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_addr <= ~a;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge i_clock);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clock);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_clock);
      q = i_rdata;
   endtask
   // one service pass; live state is polled until two reads agree, five reads at most
   task automatic service(output logic [7:0] f, output logic [7:0] s);
      logic [7:0] prev;
      rd(OFS_INT_FLAGS, f);
      if (f[3] || f[2]) begin
         rd(OFS_LIVE_STATE, s);
         prev = ~s;
         for (int i = 0; i < 4 && prev != s; i++) begin
            prev = s;
            rd(OFS_LIVE_STATE, s);
         end
      end else begin
         rd(8'h54, s);
      end
   endtask
endmodule
`default_nettype wire

//--- test/tb_ds3_rx_alarm_interrupts.sv
// self-checking bench for the receive alarm interrupt block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_ds3_rx_alarm_interrupts;
   import drai_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] addr, wdata, rdata, f, s;
   logic wr, rd, irq;
   drai_frame_t frame = '0;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   drai_top dut (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_frame(frame), .o_irq(irq));
   drai_host h (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         fails++;
         end_of_test();
      end
   end
   // one pulse, then room for the flag to land
   task automatic pulse(input drai_frame_t fr);
      @(posedge clk);
      frame <= fr;
      @(posedge clk);
      frame <= '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      h.rd(a, s);
      `CHK(s, e)
   endtask
   task automatic t_regs();
      rc(OFS_LIVE_STATE, 8'h00);
      rc(OFS_INT_ENABLE, 8'h00);
      rc(OFS_INT_FLAGS, 8'h00);
      h.wr(OFS_INT_ENABLE, 8'hF2);
      h.wr(OFS_LIVE_STATE, 8'hFF);
      rc(OFS_INT_ENABLE, 8'hF2);
      rc(OFS_LIVE_STATE, 8'h00);
      $display("regs done");
   endtask
   task automatic t_pbit();
      pulse('{1'b0, 2'h3, 1'b0, 1'b1});
      rc(OFS_INT_FLAGS, 8'h00);
      h.wr(OFS_INT_ENABLE, 8'h01);
      pulse('{1'b0, 2'h3, 1'b0, 1'b1});
      `CHK(irq, 1'b1)
      h.service(f, s);
      `CHK(f, 8'h01)
      `CHK(irq, 1'b0)
      $display("pbit done");
   endtask
   task automatic t_fef();
      h.wr(OFS_INT_ENABLE, 8'h0D);
      pulse('{1'b1, 2'h0, 1'b0, 1'b0});
      h.service(f, s);
      `CHK({f, s}, 16'h0810)
      pulse('{1'b1, 2'h2, 1'b0, 1'b0});
      h.service(f, s);
      `CHK({f, s}, 16'h0800)
      $display("fef done");
   endtask
   task automatic t_aic();
      pulse('{1'b1, 2'h2, 1'b1, 1'b0});
      h.service(f, s);
      `CHK({f, s}, 16'h0408)
      h.wr(OFS_INT_ENABLE, 8'h09);
      pulse('{1'b1, 2'h0, 1'b0, 1'b0});
      h.service(f, s);
      `CHK({f, s}, 16'h0810)
      $display("aic done");
   endtask
   // a frozen block ignores strobes and frame events alike
   task automatic t_freeze();
      @(posedge clk);
      clk_en <= 1'b0;
      h.wr(OFS_INT_ENABLE, 8'h00);
      pulse('{1'b1, 2'h2, 1'b0, 1'b1});
      @(posedge clk);
      clk_en <= 1'b1;
      rc(OFS_INT_ENABLE, 8'h09);
      rc(OFS_INT_FLAGS, 8'h00);
      rc(OFS_LIVE_STATE, 8'h10);
      h.wr(OFS_INT_ENABLE, 8'h05);
      pulse('{1'b1, 2'h2, 1'b0, 1'b0});
      rc(OFS_INT_FLAGS, 8'h00);
      rc(OFS_LIVE_STATE, 8'h00);
      `CHK(irq, 1'b0)
      $display("freeze done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_pbit();
      t_fef();
      t_aic();
      t_freeze();
      end_of_test();
   end
endmodule
`default_nettype wire
